// File: pmps_dvs.sv
// Shared constants for the power sequencer and the converter voltage stepper.
`default_nettype none

package pmps_pkg;
   // ************************************************************
   // Geometry and register map.
   // ************************************************************
   localparam int NUM_RAILS = 6;
   localparam int ADDR_W = 8;
   localparam int VCODE_W = 6;
   localparam int SLOT_W = 3;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_ENABLE = 8'h04;
   localparam logic [7:0] OFF_DISCH = 8'h08;
   localparam logic [7:0] OFF_VBANK1 = 8'h0C;
   localparam logic [7:0] OFF_VBANK2 = 8'h10;
   localparam logic [7:0] OFF_SLOT = 8'h14;
   localparam logic [7:0] OFF_STATUS = 8'h18;
   // ************************************************************
   // Field positions and reset values.
   // ************************************************************
   localparam int CTRL_MODE_BIT = 0;
   localparam int CTRL_BANK_BIT = 1;
   localparam int CTRL_STEP_BIT = 2;
   localparam int CTRL_OFFORD_BIT = 3;
   localparam int CTRL_THERMAL_RESTART_SELECT_LSB = 6;
   localparam int CTRL_DELAY_LSB = 8;
   localparam int STAT_PG_BIT = 0;
   localparam int STAT_PGEV_BIT = 1;
   localparam int STAT_WARNEV_BIT = 2;
   localparam int STAT_TSDEV_BIT = 3;
   localparam int STAT_STATE_LSB = 8;
   localparam logic MODE_RST = 1'b0;
   localparam logic BANK_RST = 1'b1;
   localparam logic STEP_RST = 1'b0;
   localparam logic OFFORD_RST = 1'b0;
   localparam logic [1:0] THERMAL_RESTART_SELECT_RST = 2'h0;
   localparam logic [2:0] DELAY_RST = 3'h0;
   localparam logic [5:0] ENABLE_RST = 6'h00;
   localparam logic [5:0] DISCH_RST = 6'h3F;
   localparam logic [5:0] VBANK_RST = 6'h08;
   localparam logic [17:0] SLOT_RST = 18'h2C688;
   localparam logic [2:0] LAST_SLOT = 3'h5;
   // ************************************************************
   // Timing, all counted in cycles of the one system clock.
   // ************************************************************
   localparam int CLK_MHZ = 20;
   localparam int SLOT_US = 128;
   localparam int BLANK_US = 50;
   localparam int CONV_BIAS_US = 32;
   localparam int BIAS_US = 128;
   localparam int STEP_FAST_NS = 2670;
   localparam int STEP_SLOW_NS = 10670;
   localparam logic [15:0] SLOT_CYC = 16'(SLOT_US * CLK_MHZ);
   localparam logic [15:0] BLANK_CYC = 16'(BLANK_US * CLK_MHZ);
   localparam logic [15:0] CONV_BIAS_CYC = 16'(CONV_BIAS_US * CLK_MHZ);
   localparam logic [15:0] BIAS_CYC = 16'(BIAS_US * CLK_MHZ);
   localparam logic [8:0] STEP_FAST_CYC =
      9'((STEP_FAST_NS * CLK_MHZ + 999) / 1000);
   localparam logic [8:0] STEP_SLOW_CYC =
      9'((STEP_SLOW_NS * CLK_MHZ + 999) / 1000);

   typedef enum logic [6:0] {
      ST_BIAS = 7'h01,
      ST_OFF = 7'h02,
      ST_DELAY = 7'h04,
      ST_UP = 7'h08,
      ST_ON = 7'h10,
      ST_DOWN = 7'h20,
      ST_TSD = 7'h40
   } pmps_state_t;
endpackage : pmps_pkg

// ************************************************************
// Converter reference stepper.
// ************************************************************
module pmps_dvs #(
   parameter int VCODE_W = 6
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic supply_ok,
   input wire logic [VCODE_W-1:0] target,
   input wire logic slow_rate,
   output logic [VCODE_W-1:0] ref_code
);
   logic [VCODE_W-1:0] ref_ff;
   logic [VCODE_W-1:0] nxt_ref;
   logic [8:0] step_ff;
   logic [8:0] nxt_step;
   wire logic [8:0] step_len;
   wire logic step_end;
   wire logic moving;

   // One code is one 50 mV step; the same pacing applies when falling, so
   // the output never ramps down faster than it would ramp up.
   assign step_len = slow_rate ? pmps_pkg::STEP_SLOW_CYC :
                                 pmps_pkg::STEP_FAST_CYC;
   assign moving = (ref_ff != target);
   assign step_end = (step_ff == step_len - 9'h001);
   assign nxt_step = (!moving || step_end) ? 9'h000 : step_ff + 9'h001;
   assign nxt_ref = !(moving && step_end) ? ref_ff :
                    (target > ref_ff) ? ref_ff + 1'b1 :
                                        ref_ff - 1'b1;
   assign ref_code = ref_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_ff <= pmps_pkg::VBANK_RST;
         step_ff <= 9'h000;
      end else if (!supply_ok) begin
         ref_ff <= pmps_pkg::VBANK_RST;
         step_ff <= 9'h000;
      end else begin
         ref_ff <= nxt_ref;
         step_ff <= nxt_step;
      end
   end
endmodule : pmps_dvs

`default_nettype wire

// File: pmps_seq.sv
// Power sequencer with APB registers, discharge and thermal handling.
//
// Functional notes
// - Supply lockout holds every register and state in reset; the APB answer flops are reset only by presetn.
// - Thermal shutdown acts only with a rail on; it turns all rails off.
// - After thermal shutdown, select 00 reloads defaults, others keep.
// - Thermal warning raises a sticky event on the host interrupt.
// - Discharge is on for all rails once supply is valid.
// - In on state each rail discharge follows its own control bit.
// - After power down, lockout or thermal shutdown discharge is forced on.
// - Lockout drops all rails at once, outputs left floating.
// - Rising chip enable starts the power-up sequencer; pin has pull-down.
// - Chip enable low powers down in reverse slot order unless set.
// - With chip enable high each rail follows its own enable bit.
// - Default slots 0..5, 128 us apart, converter first; all off.
// - Start delay in 128 us units, outputs discharged meanwhile.
// - First 50 us of bias time answer bus requests with an error.
// - Registers stay accessible while chip enable is low.
// - Enabling the converter rail in on state adds only a 32 us bias; other rails start at once.
// - Raising voltage steps 50 mV per step time until target.
// - Falling voltage is paced no faster than the step rate.
// - Converter holds two target banks selected by a bank bit.
// - Bank bit 0 picks second bank, 1 picks first; reset is 1.
// - Step rate bit 0 gives 2.67 us, 1 gives 10.67 us per step.
// - Power good is 0 during power-up, then 1 with a clearable event.
`default_nettype none

module pmps_seq #(
   parameter int NUM_RAILS = pmps_pkg::NUM_RAILS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pmps_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic supply_ok,
   input wire logic chip_enable_pin,
   input wire logic thermal_shutdown_in,
   input wire logic thermal_warning_in,
   output logic [NUM_RAILS-1:0] rail_enable,
   output logic [NUM_RAILS-1:0] rail_discharge,
   output logic conv_pwm_only,
   output logic [pmps_pkg::VCODE_W-1:0] conv_ref_code,
   output logic power_good_flag,
   output logic host_irq
);
   // ************************************************************
   // Helpers.
   // ************************************************************
   function automatic logic [2:0] slot_of(input logic [17:0] slots,
                                           input int rail);
      slot_of = slots[3*rail +: 3];
   endfunction : slot_of

   // ************************************************************
   // Storage.
   // ************************************************************
   pmps_pkg::pmps_state_t st_ff;
   pmps_pkg::pmps_state_t nxt_st;
   logic [15:0] tmr_ff;
   logic [15:0] nxt_tmr;
   logic [2:0] cur_ff;
   logic [2:0] nxt_cur;
   logic [NUM_RAILS-1:0] rail_ff;
   logic [NUM_RAILS-1:0] nxt_rail;
   logic [NUM_RAILS-1:0] dis_ff;
   logic [15:0] cb_ff;
   logic mode_ff;
   logic bank_ff;
   logic step_ff;
   logic offord_ff;
   logic [1:0] thermal_restart_select_ff;
   logic [2:0] delay_ff;
   logic [5:0] enable_ff;
   logic [5:0] disch_ff;
   logic [5:0] vb1_ff;
   logic [5:0] vb2_ff;
   logic [17:0] slot_ff;
   logic ce_q_ff;
   logic warn_q_ff;
   logic restart_ff;
   logic pg_ff;
   logic pg_ev_ff;
   logic warn_ev_ff;
   logic tsd_ev_ff;
   logic irq_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic [31:0] prdata_ff;
   logic mode_out_ff;

   // ************************************************************
   // Bus decode.
   // ************************************************************
   wire logic blank = (st_ff == pmps_pkg::ST_BIAS) &&
                      (tmr_ff < pmps_pkg::BLANK_CYC);
   wire logic acc = psel && penable;
   wire logic acc_first = acc && !pready_ff;
   wire logic acc_done = acc && pready_ff;
   wire logic hit_ctrl = (paddr == pmps_pkg::OFF_CTRL);
   wire logic hit_en = (paddr == pmps_pkg::OFF_ENABLE);
   wire logic hit_dis = (paddr == pmps_pkg::OFF_DISCH);
   wire logic hit_vb1 = (paddr == pmps_pkg::OFF_VBANK1);
   wire logic hit_vb2 = (paddr == pmps_pkg::OFF_VBANK2);
   wire logic hit_slot = (paddr == pmps_pkg::OFF_SLOT);
   wire logic hit_stat = (paddr == pmps_pkg::OFF_STATUS);
   wire logic mapped = hit_ctrl || hit_en || hit_dis || hit_vb1 ||
                       hit_vb2 || hit_slot || hit_stat;
   // Writes are refused while blanking, the bus form of a not-acknowledge.
   wire logic wr_ok = acc_done && pwrite && !pslverr_ff;
   wire logic stat_rd = acc_done && !pwrite && hit_stat && !pslverr_ff;
   wire logic [31:0] ctrl_word = {21'h0, delay_ff, thermal_restart_select_ff, 2'h0,
                                  offord_ff, step_ff, bank_ff, mode_ff};
   wire logic [31:0] stat_word = {17'h0, st_ff, 4'h0, tsd_ev_ff,
                                  warn_ev_ff, pg_ev_ff, pg_ff};
   wire logic [31:0] rd_word =
      hit_ctrl ? ctrl_word :
      hit_en ? {26'h0, enable_ff} :
      hit_dis ? {26'h0, disch_ff} :
      hit_vb1 ? {26'h0, vb1_ff} :
      hit_vb2 ? {26'h0, vb2_ff} :
      hit_slot ? {14'h0, slot_ff} :
      hit_stat ? stat_word : 32'h0;

   // ************************************************************
   // Sequencer decode.
   // ************************************************************
   wire logic ce_rise = chip_enable_pin && !ce_q_ff;
   wire logic tsd_armed = |rail_ff;
   wire logic slot_end = (tmr_ff == pmps_pkg::SLOT_CYC - 16'h0001);
   wire logic [15:0] delay_cyc = 16'(delay_ff * pmps_pkg::SLOT_CYC);
   wire logic [2:0] down_first = offord_ff ? 3'h0 : pmps_pkg::LAST_SLOT;
   wire logic down_last = offord_ff ? (cur_ff == pmps_pkg::LAST_SLOT) :
                                      (cur_ff == 3'h0);
   wire logic [2:0] down_next = offord_ff ? cur_ff + 3'h1 : cur_ff - 3'h1;
   // A converter already running needs no bias wait on entry to on state.
   wire logic conv_ready = (cb_ff == pmps_pkg::CONV_BIAS_CYC) || rail_ff[0];
   wire logic [NUM_RAILS-1:0] on_rails = {enable_ff[5:1],
                                          enable_ff[0] && conv_ready};
   wire logic [NUM_RAILS-1:0] slot_hit;
   wire logic reload = (st_ff == pmps_pkg::ST_TSD) &&
                       !thermal_shutdown_in && (thermal_restart_select_ff == 2'h0);

   genvar gi;
   generate
      for (gi = 0; gi < NUM_RAILS; gi++) begin : g_hit
         assign slot_hit[gi] = (slot_of(slot_ff, gi) == cur_ff);
      end
   endgenerate

   always_comb begin
      nxt_st = st_ff;
      nxt_tmr = tmr_ff + 16'h0001;
      nxt_cur = cur_ff;
      nxt_rail = rail_ff;
      case (st_ff)
         pmps_pkg::ST_BIAS: begin
            nxt_rail = '0;
            if (tmr_ff == pmps_pkg::BIAS_CYC - 16'h0001) begin
               nxt_st = pmps_pkg::ST_OFF;
            end
         end
         pmps_pkg::ST_OFF: begin
            nxt_rail = '0;
            nxt_cur = 3'h0;
            if (ce_rise || (chip_enable_pin && restart_ff)) begin
               nxt_st = (delay_ff == 3'h0) ? pmps_pkg::ST_UP :
                                             pmps_pkg::ST_DELAY;
            end
         end
         pmps_pkg::ST_DELAY: begin
            if (!chip_enable_pin) begin
               nxt_st = pmps_pkg::ST_OFF;
            end else if (tmr_ff == delay_cyc - 16'h0001) begin
               nxt_st = pmps_pkg::ST_UP;
            end
         end
         pmps_pkg::ST_UP: begin
            if (!chip_enable_pin) begin
               nxt_st = pmps_pkg::ST_DOWN;
            end else if (slot_end) begin
               nxt_rail = rail_ff | (slot_hit & enable_ff);
               nxt_cur = cur_ff + 3'h1;
               if (cur_ff == pmps_pkg::LAST_SLOT) begin
                  nxt_st = pmps_pkg::ST_ON;
               end
            end
         end
         pmps_pkg::ST_ON: begin
            nxt_rail = on_rails;
            if (!chip_enable_pin) begin
               nxt_st = pmps_pkg::ST_DOWN;
               nxt_cur = down_first;
            end
         end
         pmps_pkg::ST_DOWN: begin
            if (slot_end) begin
               nxt_rail = rail_ff & ~slot_hit;
               nxt_cur = down_next;
               if (down_last) begin
                  nxt_st = pmps_pkg::ST_OFF;
               end
            end
         end
         pmps_pkg::ST_TSD: begin
            nxt_rail = '0;
            if (!thermal_shutdown_in) begin
               nxt_st = pmps_pkg::ST_OFF;
            end
         end
         default: begin
            nxt_st = pmps_pkg::ST_BIAS;
            nxt_rail = '0;
         end
      endcase
      if (thermal_shutdown_in && tsd_armed &&
          st_ff != pmps_pkg::ST_TSD) begin
         nxt_st = pmps_pkg::ST_TSD;
         nxt_rail = '0;
      end
      if (nxt_st != st_ff) begin
         nxt_tmr = 16'h0000;
      end else if (st_ff != pmps_pkg::ST_BIAS && st_ff != pmps_pkg::ST_DELAY
                   && slot_end) begin
         nxt_tmr = 16'h0000;
      end
   end

   // Discharge is forced wherever a rail is not supposed to be up; only the
   // on state hands the choice to software.
   wire logic [NUM_RAILS-1:0] nxt_dis =
      (nxt_st == pmps_pkg::ST_ON) ? disch_ff :
                                    ~nxt_rail;

   // ************************************************************
   // Sequencer state.
   // ************************************************************
   // Lockout acts as a synchronous reset on top of the pin reset.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= pmps_pkg::ST_BIAS;
         tmr_ff <= 16'h0000;
         cur_ff <= 3'h0;
         rail_ff <= '0;
         dis_ff <= '0;
      end else if (!supply_ok) begin
         st_ff <= pmps_pkg::ST_BIAS;
         tmr_ff <= 16'h0000;
         cur_ff <= 3'h0;
         rail_ff <= '0;
         dis_ff <= '0;
      end else begin
         st_ff <= nxt_st;
         tmr_ff <= nxt_tmr;
         cur_ff <= nxt_cur;
         rail_ff <= nxt_rail;
         dis_ff <= nxt_dis;
      end
   end

   // Converter bias wait, restarted whenever the converter enable bit is clear or the state is not on.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cb_ff <= 16'h0000;
      end else if (!supply_ok || !enable_ff[0] ||
                   st_ff != pmps_pkg::ST_ON) begin
         cb_ff <= 16'h0000;
      end else if (rail_ff[0]) begin
         cb_ff <= pmps_pkg::CONV_BIAS_CYC;
      end else if (!conv_ready) begin
         cb_ff <= cb_ff + 16'h0001;
      end
   end

   // ************************************************************
   // Software registers.
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {mode_ff, bank_ff, step_ff, offord_ff} <= {pmps_pkg::MODE_RST,
            pmps_pkg::BANK_RST, pmps_pkg::STEP_RST, pmps_pkg::OFFORD_RST};
         thermal_restart_select_ff <= pmps_pkg::THERMAL_RESTART_SELECT_RST;
         delay_ff <= pmps_pkg::DELAY_RST;
         enable_ff <= pmps_pkg::ENABLE_RST;
         disch_ff <= pmps_pkg::DISCH_RST;
         vb1_ff <= pmps_pkg::VBANK_RST;
         vb2_ff <= pmps_pkg::VBANK_RST;
         slot_ff <= pmps_pkg::SLOT_RST;
      end else if (!supply_ok || reload) begin
         {mode_ff, bank_ff, step_ff, offord_ff} <= {pmps_pkg::MODE_RST,
            pmps_pkg::BANK_RST, pmps_pkg::STEP_RST, pmps_pkg::OFFORD_RST};
         thermal_restart_select_ff <= pmps_pkg::THERMAL_RESTART_SELECT_RST;
         delay_ff <= pmps_pkg::DELAY_RST;
         enable_ff <= pmps_pkg::ENABLE_RST;
         disch_ff <= pmps_pkg::DISCH_RST;
         vb1_ff <= pmps_pkg::VBANK_RST;
         vb2_ff <= pmps_pkg::VBANK_RST;
         slot_ff <= pmps_pkg::SLOT_RST;
      end else if (wr_ok) begin
         if (hit_ctrl) begin
            mode_ff <= pwdata[pmps_pkg::CTRL_MODE_BIT];
            bank_ff <= pwdata[pmps_pkg::CTRL_BANK_BIT];
            step_ff <= pwdata[pmps_pkg::CTRL_STEP_BIT];
            offord_ff <= pwdata[pmps_pkg::CTRL_OFFORD_BIT];
            thermal_restart_select_ff <= pwdata[pmps_pkg::CTRL_THERMAL_RESTART_SELECT_LSB +: 2];
            delay_ff <= pwdata[pmps_pkg::CTRL_DELAY_LSB +: 3];
         end
         if (hit_en) begin
            enable_ff <= pwdata[5:0];
         end
         if (hit_dis) begin
            disch_ff <= pwdata[5:0];
         end
         if (hit_vb1) begin
            vb1_ff <= pwdata[5:0];
         end
         if (hit_vb2) begin
            vb2_ff <= pwdata[5:0];
         end
         if (hit_slot) begin
            slot_ff <= pwdata[17:0];
         end
      end
   end

   // ************************************************************
   // Events and status.
   // ************************************************************
   // A new event in the cycle of a clearing read is kept: set wins.
   wire logic pg_set = (nxt_st == pmps_pkg::ST_ON) &&
                       (st_ff == pmps_pkg::ST_UP);
   wire logic warn_set = thermal_warning_in && !warn_q_ff;
   wire logic tsd_set = (nxt_st == pmps_pkg::ST_TSD) &&
                        (st_ff != pmps_pkg::ST_TSD);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ce_q_ff <= 1'b0;
         warn_q_ff <= 1'b0;
         restart_ff <= 1'b0;
         pg_ff <= 1'b0;
         pg_ev_ff <= 1'b0;
         warn_ev_ff <= 1'b0;
         tsd_ev_ff <= 1'b0;
         irq_ff <= 1'b0;
         mode_out_ff <= pmps_pkg::MODE_RST;
      end else if (!supply_ok) begin
         ce_q_ff <= 1'b0;
         warn_q_ff <= 1'b0;
         restart_ff <= 1'b0;
         pg_ff <= 1'b0;
         pg_ev_ff <= 1'b0;
         warn_ev_ff <= 1'b0;
         tsd_ev_ff <= 1'b0;
         irq_ff <= 1'b0;
         mode_out_ff <= pmps_pkg::MODE_RST;
      end else begin
         ce_q_ff <= chip_enable_pin;
         warn_q_ff <= thermal_warning_in;
         restart_ff <= (st_ff == pmps_pkg::ST_TSD) ||
                       (restart_ff && st_ff == pmps_pkg::ST_OFF &&
                        chip_enable_pin);
         pg_ff <= (nxt_st == pmps_pkg::ST_ON);
         pg_ev_ff <= pg_set || (pg_ev_ff && !stat_rd &&
                                chip_enable_pin);
         warn_ev_ff <= warn_set || (warn_ev_ff && !stat_rd);
         tsd_ev_ff <= tsd_set || (tsd_ev_ff && !stat_rd);
         irq_ff <= (pg_set || warn_set || tsd_set) ||
                   ((pg_ev_ff || warn_ev_ff || tsd_ev_ff) &&
                    !stat_rd);
         mode_out_ff <= mode_ff;
      end
   end

   // ************************************************************
   // APB answer: one wait state, data and error set up together.
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0;
      end else begin
         pready_ff <= acc_first;
         pslverr_ff <= acc_first && (blank || !mapped);
         prdata_ff <= (acc_first && !pwrite && !blank) ? rd_word : 32'h0;
      end
   end

   // ************************************************************
   // Converter target selection and stepping.
   // ************************************************************
   wire logic [5:0] vtarget = bank_ff ? vb1_ff : vb2_ff;

   pmps_dvs #(
      .VCODE_W(pmps_pkg::VCODE_W)
   ) u_dvs (
      .pclk(pclk),
      .presetn(presetn),
      .supply_ok(supply_ok),
      .target(vtarget),
      .slow_rate(step_ff),
      .ref_code(conv_ref_code)
   );

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign rail_enable = rail_ff;
   assign rail_discharge = dis_ff;
   assign conv_pwm_only = mode_out_ff;
   assign power_good_flag = pg_ff;
   assign host_irq = irq_ff;
endmodule : pmps_seq

`default_nettype wire

// File: pmps_seq_asserts.sv
// Concurrent checks on the sequencer top-level ports.
`default_nettype none
module pmps_seq_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic supply_ok,
   input wire logic thermal_shutdown_in,
   input wire logic [5:0] rail_enable,
   input wire logic [5:0] rail_discharge,
   input wire logic conv_pwm_only,
   input wire logic [5:0] conv_ref_code,
   input wire logic power_good_flag,
   input wire logic host_irq
);
   logic [11:0] age;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ****
   // Cycles since the supply became valid; saturates.
   // ****
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) age <= 12'h000;
      else if (!supply_ok) age <= 12'h000;
      else if (age != 12'hFFF) age <= age + 12'h001;
   end
   sequence s_idle;
      (supply_ok && rail_enable == 6'h00 && !power_good_flag) [*2];
   endsequence
   sequence s_hold;
      $stable(conv_ref_code) [*8];
   endsequence
   property p_lock;
      !supply_ok |=> rail_enable == 6'h00 && !power_good_flag;
   endproperty
   a_lock: assert property (p_lock)
      else $error("lockout left outputs active");
   property p_tsd;
      thermal_shutdown_in && rail_enable != 6'h00
         |-> ##[1:3] rail_enable == 6'h00;
   endproperty
   a_tsd: assert property (p_tsd)
      else $error("rails stayed on in thermal shutdown");
   property p_disch;
      s_idle |-> rail_discharge == 6'h3F;
   endproperty
   a_disch: assert property (p_disch)
      else $error("discharge not forced while idle");
   property p_pgirq;
      $rose(power_good_flag) |-> ##[0:2] host_irq;
   endproperty
   a_pgirq: assert property (p_pgirq)
      else $error("no interrupt after power good");
   property p_blank;
      pready && age < 12'h3DE |-> pslverr;
   endproperty
   a_blank: assert property (p_blank)
      else $error("access accepted during blanking");
   property p_apb;
      $rose(penable) && age > 12'h44C && paddr <= 8'h18
         && paddr[1:0] == 2'h0 |=> pready && !pslverr;
   endproperty
   a_apb: assert property (p_apb)
      else $error("mapped access not answered");
   property p_mode;
      psel && penable && pready && pwrite && !pslverr && paddr == 8'h00
         |-> ##2 conv_pwm_only == $past(pwdata[0], 2);
   endproperty
   a_mode: assert property (p_mode)
      else $error("mode output differs from control bit");
   property p_step;
      $changed(conv_ref_code) && $past(supply_ok)
         |-> (conv_ref_code == $past(conv_ref_code) + 6'h01
         || conv_ref_code + 6'h01 == $past(conv_ref_code)) ##1 s_hold;
   endproperty
   a_step: assert property (p_step)
      else $error("reference moved by more than one step");
endmodule : pmps_seq_asserts
`default_nettype wire

// File: pmps_host.sv
// Host model: APB master issuing one transfer at a time.
`default_nettype none
module pmps_host (
   input wire logic pclk,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial {psel, penable, pwrite, paddr, pwdata} = '0;
   // Called just after an edge; an idle edge follows so calls never collide.
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
      {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
      @(posedge pclk) penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      q = prdata;
      e = pslverr;
      {psel, penable} <= 2'h0;
      @(posedge pclk);
   endtask : xfer
endmodule : pmps_host
`default_nettype wire

// File: pmic_power_sequencer_dvs_tb_top.sv
// Testbench for the power sequencer: registers, sequencing and stepping.
`default_nettype none
module pmic_power_sequencer_dvs_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int SL = int'(pmps_pkg::SLOT_CYC);
   localparam logic [7:0] RA [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10,
      8'h14, 8'h18};
   localparam logic [31:0] RV [7] = '{32'h2, 32'h0, 32'h3F, 32'h8, 32'h8,
      32'h2C688, 32'h200};
   logic pclk = 1'h0, presetn = 1'h0, supply_ok = 1'h1, ce = 1'h0;
   logic tsd = 1'h0, warn = 1'h0, psel, penable, pwrite, pready, pslverr;
   logic pwm, pg, irq, e;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [5:0] ren, rdis, code;
   int fail_count = 0, checks = 0;
   always #25 pclk = ~pclk;
   pmps_seq u_pmps_seq (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .supply_ok,
      .chip_enable_pin(ce), .thermal_shutdown_in(tsd),
      .thermal_warning_in(warn), .rail_enable(ren), .rail_discharge(rdis),
      .conv_pwm_only(pwm), .conv_ref_code(code), .power_good_flag(pg),
      .host_irq(irq));
   pmps_host u_pmps_host (.pclk, .pready, .pslverr, .prdata, .psel,
      .penable, .pwrite, .paddr, .pwdata);
   task automatic chk(input string n, input logic [31:0] x,
      input logic [31:0] g);
      checks++;
      if (g !== x) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, x, g);
      end
   endtask : chk
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      u_pmps_host.xfer(1'h0, a, 32'h0, q, e);
      chk("read data", x, q);
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_pmps_host.xfer(1'h1, a, d, q, e);
   endtask : wr
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc
   task automatic end_sim;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim
   initial begin
      cyc(5);
      presetn <= 1'h1;
      cyc(2);
      u_pmps_host.xfer(1'h0, 8'h00, 32'h0, q, e);
      chk("blank error", 32'h1, 32'(e));
      cyc(2600);
      foreach (RA[i]) rd(RA[i], RV[i]);
      u_pmps_host.xfer(1'h0, 8'h1C, 32'h0, q, e);
      chk("unmapped error", 32'h1, 32'(e));
      wr(8'h10, 32'h0A);
      wr(8'h00, 32'h0);
      cyc(140);
      chk("ref code", 32'h0A, 32'(code));
      wr(8'h00, 32'h107);
      cyc(120);
      chk("slow step", 32'h1, 32'(code !== 6'h08));
      cyc(500);
      chk("ref code", 32'h08, 32'(code));
      chk("pwm only", 32'h1, 32'(pwm));
      wr(8'h04, 32'h3F);
      ce <= 1'h1;
      cyc(SL - 10);
      chk("delay rails", 32'h0, 32'(ren));
      chk("delay disch", 32'h3F, 32'(rdis));
      cyc(SL + 20);
      chk("slot0 rails", 32'h01, 32'(ren));
      for (int i = 0; i < 5 * SL + 100 && pg !== 1'h1; i++) cyc(1);
      chk("on rails", 32'h3F, 32'(ren));
      chk("pg irq", 32'h1, 32'(irq));
      wr(8'h08, 32'h15);
      cyc(3);
      chk("on disch", 32'h15, 32'(rdis));
      wr(8'h04, 32'h3D);
      cyc(3);
      chk("rail write", 32'h3D, 32'(ren));
      rd(8'h18, 32'h1003);
      warn <= 1'h1;
      cyc(3);
      chk("warn irq", 32'h1, 32'(irq));
      warn <= 1'h0;
      rd(8'h18, 32'h1005);
      ce <= 1'h0;
      cyc(SL + 10);
      chk("down order", 32'h1D, 32'(ren));
      cyc(5 * SL);
      chk("off disch", 32'h3F, 32'(rdis));
      tsd <= 1'h1;
      cyc(5);
      rd(8'h18, 32'h200);
      tsd <= 1'h0;
      supply_ok <= 1'h0;
      cyc(3);
      supply_ok <= 1'h1;
      cyc(2600);
      rd(8'h00, 32'h2);
      wr(8'h04, 32'h01);
      ce <= 1'h1;
      cyc(SL + 10);
      chk("tsd rail0", 32'h01, 32'(ren));
      tsd <= 1'h1;
      cyc(3);
      chk("tsd rails", 32'h0, 32'(ren));
      rd(8'h18, 32'h4008);
      tsd <= 1'h0;
      cyc(3);
      rd(8'h04, 32'h0);
      end_sim();
   end
   initial begin
      cyc(60000);
      fail_count++;
      end_sim();
   end
endmodule : pmic_power_sequencer_dvs_tb_top
bind pmps_seq pmps_seq_asserts u_pmps_seq_asserts (.*);
`default_nettype wire
